// File: core/ims_bit_timer.sv
`timescale 1ns/1ps
module ims_bit_timer
   import ims_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       load,
   input  wire logic       halt,
   input  wire logic [7:0] reload,
   output logic            expired
);

   typedef struct packed {
      logic [7:0] cnt;
      logic       run;
   } ims_tmr_t;

   ims_tmr_t r;
   ims_tmr_t n;

   // One period is reload+1 cycles; stops at zero until reloaded
   always_comb begin
      n       = r;
      expired = r.run & (r.cnt == 8'h00);
      if (halt) begin
         n.run = 1'b0;
      end else if (load) begin
         n.cnt = reload;
         n.run = 1'b1;
      end else if (r.run) begin
         if (r.cnt == 8'h00) begin
            n.run = 1'b0;
         end else begin
            n.cnt = r.cnt - 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

endmodule : ims_bit_timer

// File: core/ims_sequencer.sv
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////
// How it works
// - A zero mask bit makes that received address bit a don't-care.
// - The address mask resets to all ones, giving exact matching.
// - Seven-bit mode masks only received address bits seven to one.
// - Ten-bit mode masks the low byte fully; high byte compares exactly.
// - Master mode needs mode code plus enable; lines are only pulled low.
// - Reset or disable clears start/stop seen; take bus only when free.
// - Firmware master mode keeps only start/stop detection; software drives lines.
// - Event flag rises on start, stop or repeated start.
// - Buffer writes before a requested start finishes are dropped with collision flag.
// - Hardware master masks detection events; event follows request completion instead.
// - Master makes clocks, start, stop; repeated start keeps the bus owned.
// - First byte is address plus direction; bytes move eight bits with acknowledge.
// - Released clock halts the timer until clock is high, then reloads.
// - Buffer writes during any sequence are dropped and flag write collision.
// - Low five control_two bits ignore writes while a start is pending.
// - Start loads timer with lines high; at timeout pulls data low.
// - Start holds data low one more period, then clears its request.
// - Low lines at start, or clock low early, flag collision and abort.
// - Restart pulls clock low, releases data one period, then releases clock.
// - Restart holds both high, data low one period, clock low, then completes.
// - Start seen rises as data is pulled low; event waits for the timer.
// - Restart requests made while any operation runs are ignored.
//////////////////////////////////////////////////////////////////////////////////////////
module ims_sequencer
   import ims_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe_n,
   input  wire logic        byte_busy,
   input  wire logic [7:0]  rsr_byte,
   input  wire logic        rsr_high_byte,
   output logic [7:0]       tx_data,
   output logic             tx_load,
   output logic             addr_match
);

   typedef struct packed {
      logic        sda_m;
      logic        sda_s;
      logic        sda_d;
      logic        scl_m;
      logic        scl_s;
      logic [7:0]  ctrl_one;
      logic [4:0]  ctrl_two;
      logic        start_seen;
      logic        stop_seen;
      logic        evt;
      logic        write_collision_flag;
      logic        coll;
      logic [7:0]  baud;
      logic [7:0]  txbuf;
      logic [7:0]  mask;
      logic [7:0]  own_addr;
      logic        sda_low;
      logic        scl_low;
      ims_state_t  state;
      logic        tx_load;
      logic        match;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } ims_regs_t;

   ims_regs_t r;
   ims_regs_t n;

   logic       t_load;
   logic       t_halt;
   logic       t_exp;
   logic       en;
   logic       hw_master;
   logic       fw_master;
   logic       start_det;
   logic       stop_det;
   logic       busy;
   logic       bus_free;
   logic       wr_go;
   logic       rd_go;
   logic [7:0] cmp_mask;

   //////////////////////////////////////////////////////////////////////////////////////
   // Bit period timer
   ims_bit_timer u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (t_load),
      .halt    (t_halt),
      .reload  (r.baud),
      .expired (t_exp)
   );

   //////////////////////////////////////////////////////////////////////////////////////
   // Bus handshakes and pin drivers
   assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~r.bvalid;
   assign rd_go         = s_axi_arvalid & ~r.rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = ~r.rvalid;
   assign s_axi_bvalid  = r.bvalid;
   assign s_axi_bresp   = r.bresp;
   assign s_axi_rvalid  = r.rvalid;
   assign s_axi_rresp   = r.rresp;
   assign s_axi_rdata   = r.rdata;
   assign sda_out       = 1'b0;                        // Open drain: only ever pulls low
   assign scl_out       = 1'b0;
   assign tx_data       = r.txbuf;
   assign tx_load       = r.tx_load;
   assign addr_match    = r.match;

   // Line drivers: firmware mode hands the lines to software
   always_comb begin
      if (fw_master) begin
         sda_oe_n = ~r.ctrl_one[C1_FW_SDA_LO];
         scl_oe_n = ~r.ctrl_one[C1_FW_SCL_LO];
      end else begin
         sda_oe_n = ~r.sda_low;
         scl_oe_n = ~r.scl_low;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      n         = r;
      t_load    = 1'b0;
      t_halt    = 1'b0;
      n.tx_load = 1'b0;

      // Two-stage synchronisers, plus one delayed copy of data for edges
      n.sda_m = sda_in;
      n.sda_s = r.sda_m;
      n.sda_d = r.sda_s;
      n.scl_m = scl_in;
      n.scl_s = r.scl_m;

      en        = r.ctrl_one[C1_ENABLE];
      hw_master = en & (r.ctrl_one[3:0] == MODE_HW_MASTER);
      fw_master = en & (r.ctrl_one[3:0] == MODE_FW_MASTER);
      start_det = r.sda_d & ~r.sda_s & r.scl_s;
      stop_det  = ~r.sda_d & r.sda_s & r.scl_s;
      busy      = (r.state != ST_IDLE) | byte_busy | (|r.ctrl_two[C2_STOP:C2_START]);
      bus_free  = r.stop_seen | ~r.start_seen;

      // Address compare against the receive shift register
      if (r.ctrl_one[C1_TEN_BIT]) begin
         cmp_mask = rsr_high_byte ? 8'hFF : r.mask;
      end else begin
         cmp_mask = r.mask & MASK_7BIT;
      end
      n.match = ((rsr_byte ^ r.own_addr) & cmp_mask) == 8'h00;

      // Write channel: both address and data taken together
      if (r.bvalid & s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (wr_go) begin
         n.bvalid = 1'b1;
         n.bresp  = RESP_OKAY;
         if (s_axi_wstrb[0]) begin
            case (s_axi_awaddr)
               OFS_CTRL_ONE: begin
                  n.ctrl_one = s_axi_wdata[7:0];
               end
               OFS_CTRL_TWO: begin
                  if (!r.ctrl_two[C2_START]) begin
                     n.ctrl_two[C2_START] = s_axi_wdata[C2_START];
                     n.ctrl_two[C2_STOP]  = s_axi_wdata[C2_STOP];
                     n.ctrl_two[4:C2_SPARE_LO] = s_axi_wdata[4:C2_SPARE_LO];
                     if (!busy) begin
                        n.ctrl_two[C2_RESTART] = s_axi_wdata[C2_RESTART];
                     end
                  end
               end
               OFS_FLAGS: begin
                  if (s_axi_wdata[FL_EVENT]) n.evt  = 1'b0;
                  if (s_axi_wdata[FL_WRITE_COLLISION_FLAG])  n.write_collision_flag = 1'b0;
                  if (s_axi_wdata[FL_COLL])  n.coll = 1'b0;
               end
               OFS_BAUD: begin
                  n.baud = s_axi_wdata[7:0];
               end
               OFS_TXBUF: begin
                  if (busy) begin
                     n.write_collision_flag = 1'b1;
                  end else begin
                     n.txbuf   = s_axi_wdata[7:0];
                     n.tx_load = 1'b1;
                  end
               end
               OFS_MASK: begin
                  n.mask = s_axi_wdata[7:0];
               end
               OFS_OWN_ADDR: begin
                  n.own_addr = s_axi_wdata[7:0];
               end
               OFS_STATUS: begin
               end
               default: begin
                  n.bresp = RESP_SLVERR;
               end
            endcase
         end else if (!(s_axi_awaddr inside {OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_STATUS,
                        OFS_FLAGS, OFS_BAUD, OFS_TXBUF, OFS_MASK, OFS_OWN_ADDR})) begin
            n.bresp = RESP_SLVERR;
         end
      end

      // Read channel
      if (r.rvalid & s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (rd_go) begin
         n.rvalid = 1'b1;
         n.rresp  = RESP_OKAY;
         n.rdata  = 32'h0000_0000;
         case (s_axi_araddr)
            OFS_CTRL_ONE: n.rdata[7:0] = r.ctrl_one;
            OFS_CTRL_TWO: n.rdata[4:0] = r.ctrl_two;
            OFS_STATUS:   n.rdata[5:0] = {r.match, r.scl_s, r.sda_s, busy,
                                          r.stop_seen, r.start_seen};
            OFS_FLAGS:    n.rdata[2:0] = {r.coll, r.write_collision_flag, r.evt};
            OFS_BAUD:     n.rdata[7:0] = r.baud;
            OFS_TXBUF:    n.rdata[7:0] = r.txbuf;
            OFS_MASK:     n.rdata[7:0] = r.mask;
            OFS_OWN_ADDR: n.rdata[7:0] = r.own_addr;
            default:      n.rresp      = RESP_SLVERR;
         endcase
      end

      // Start and stop detection on the synchronised lines
      if (start_det) begin
         n.start_seen = 1'b1;
         n.stop_seen  = 1'b0;
      end
      if (stop_det) begin
         n.stop_seen  = 1'b1;
         n.start_seen = 1'b0;
      end
      if ((start_det | stop_det) & en & ~hw_master) begin
         n.evt = 1'b1;
      end

      // Master sequencer
      case (r.state)
         ST_IDLE: begin
            if (!hw_master) begin
            end else if (r.ctrl_two[C2_START]) begin
               if (!r.sda_s & !r.scl_s) begin
                  n.coll = 1'b1;
                  n.ctrl_two[C2_START] = 1'b0;
               end else if (r.sda_s & r.scl_s & bus_free) begin
                  t_load  = 1'b1;
                  n.state = ST_S_WAIT;
               end
            end else if (r.ctrl_two[C2_RESTART]) begin
               n.scl_low = 1'b1;
               n.state   = ST_R_SCL_LOW;
            end else if (r.ctrl_two[C2_STOP]) begin
               n.scl_low = 1'b1;
               n.sda_low = 1'b1;
               n.state   = ST_P_SCL_LOW;
            end
         end
         ST_S_WAIT: begin
            if (!r.scl_s) begin
               n.state = ST_IDLE;
               n.coll  = 1'b1;
               n.ctrl_two[C2_START] = 1'b0;
               t_halt  = 1'b1;
            end else if (t_exp) begin
               if (r.sda_s) begin
                  n.sda_low    = 1'b1;
                  n.start_seen = 1'b1;
                  n.stop_seen  = 1'b0;
                  t_load       = 1'b1;
                  n.state      = ST_S_HOLD;
               end else begin
                  n.state = ST_IDLE;
                  n.coll  = 1'b1;
                  n.ctrl_two[C2_START] = 1'b0;
               end
            end
         end
         ST_S_HOLD: begin
            if (t_exp) begin
               n.ctrl_two[C2_START] = 1'b0;
               n.evt   = 1'b1;
               n.state = ST_IDLE;
            end
         end
         ST_R_SCL_LOW: begin
            if (!r.scl_s) begin
               n.sda_low = 1'b0;
               t_load    = 1'b1;
               n.state   = ST_R_SDA_REL;
            end
         end
         ST_R_SDA_REL: begin
            if (t_exp) begin
               if (r.sda_s) begin
                  n.scl_low = 1'b0;
                  n.state   = ST_R_SCL_REL;
               end else begin
                  n.state   = ST_IDLE;
                  n.coll    = 1'b1;
                  n.scl_low = 1'b0;
                  n.ctrl_two[C2_RESTART] = 1'b0;
               end
            end
         end
         ST_R_SCL_REL: begin
            if (r.scl_s) begin
               if (!r.sda_s) begin
                  n.state = ST_IDLE;
                  n.coll  = 1'b1;
                  n.ctrl_two[C2_RESTART] = 1'b0;
               end else begin
                  t_load  = 1'b1;
                  n.state = ST_R_HIGH;
               end
            end
         end
         ST_R_HIGH: begin
            if (!r.scl_s) begin
               n.state = ST_IDLE;
               n.coll  = 1'b1;
               n.ctrl_two[C2_RESTART] = 1'b0;
               t_halt  = 1'b1;
            end else if (t_exp) begin
               n.sda_low = 1'b1;
               t_load    = 1'b1;
               n.state   = ST_R_SDA_LOW;
            end
         end
         ST_R_SDA_LOW: begin
            if (t_exp) begin
               n.scl_low = 1'b1;
               n.ctrl_two[C2_RESTART] = 1'b0;
               n.evt     = 1'b1;
               n.state   = ST_IDLE;
            end
         end
         ST_P_SCL_LOW: begin
            if (!r.scl_s) begin
               t_load  = 1'b1;
               n.state = ST_P_LOW;
            end
         end
         ST_P_LOW: begin
            if (t_exp) begin
               n.scl_low = 1'b0;
               n.state   = ST_P_SCL_REL;
            end
         end
         ST_P_SCL_REL: begin
            if (r.scl_s) begin
               t_load  = 1'b1;
               n.state = ST_P_HIGH;
            end
         end
         ST_P_HIGH: begin
            if (t_exp) begin
               n.sda_low = 1'b0;
               t_load    = 1'b1;
               n.state   = ST_P_SDA_REL;
            end
         end
         ST_P_SDA_REL: begin
            if (t_exp) begin
               n.ctrl_two[C2_STOP] = 1'b0;
               n.evt     = 1'b1;
               n.state   = ST_IDLE;
            end
         end
         default: begin
            n.state = ST_IDLE;
         end
      endcase

      // Collision or mode change releases both lines
      if ((n.coll & ~r.coll) | ~hw_master) begin
         n.sda_low = 1'b0;
         n.scl_low = 1'b0;
         n.state   = ST_IDLE;
         t_halt    = 1'b1;
      end

      // Disabled port drops everything it was doing
      if (!en) begin
         n.start_seen = 1'b0;
         n.stop_seen  = 1'b0;
         n.ctrl_two[C2_STOP:C2_START] = 3'h0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r          <= '0;
         r.sda_m    <= 1'b1;
         r.sda_s    <= 1'b1;
         r.sda_d    <= 1'b1;
         r.scl_m    <= 1'b1;
         r.scl_s    <= 1'b1;
         r.ctrl_one <= CTRL_ONE_RST;
         r.baud     <= BAUD_RST;
         r.mask     <= MASK_RST;
         r.own_addr <= OWN_ADDR_RST;
         r.state    <= ST_IDLE;
      end else begin
         r <= n;
      end
   end

endmodule : ims_sequencer

// File: shared/ims_pkg.sv
package ims_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
   localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
   localparam logic [7:0] OFS_STATUS   = 8'h08;
   localparam logic [7:0] OFS_FLAGS    = 8'h0C;
   localparam logic [7:0] OFS_BAUD     = 8'h10;
   localparam logic [7:0] OFS_TXBUF    = 8'h14;
   localparam logic [7:0] OFS_MASK     = 8'h18;
   localparam logic [7:0] OFS_OWN_ADDR = 8'h1C;

   // control_one fields
   localparam int C1_MODE_LO   = 0;
   localparam int C1_ENABLE    = 4;
   localparam int C1_TEN_BIT   = 5;
   localparam int C1_FW_SCL_LO = 6;
   localparam int C1_FW_SDA_LO = 7;

   // control_two fields
   localparam int C2_START     = 0;
   localparam int C2_RESTART   = 1;
   localparam int C2_STOP      = 2;
   localparam int C2_SPARE_LO  = 3;

   // Flag fields (write one to clear)
   localparam int FL_EVENT     = 0;
   localparam int FL_WRITE_COLLISION_FLAG      = 1;
   localparam int FL_COLL      = 2;

   // mode_select_field codes
   localparam logic [3:0] MODE_HW_MASTER = 4'h8;
   localparam logic [3:0] MODE_FW_MASTER = 4'hB;

   // Reset values
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] BAUD_RST     = 8'h00;
   localparam logic [7:0] MASK_RST     = 8'hFF;
   localparam logic [7:0] OWN_ADDR_RST = 8'h00;

   // Mask bits used for seven-bit compares
   localparam logic [7:0] MASK_7BIT    = 8'hFE;

   // AXI responses
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // Sequencer states
   typedef enum logic [12:0] {
      ST_IDLE      = 13'h0001,
      ST_S_WAIT    = 13'h0002,
      ST_S_HOLD    = 13'h0004,
      ST_R_SCL_LOW = 13'h0008,
      ST_R_SDA_REL = 13'h0010,
      ST_R_SCL_REL = 13'h0020,
      ST_R_HIGH    = 13'h0040,
      ST_R_SDA_LOW = 13'h0080,
      ST_P_SCL_LOW = 13'h0100,
      ST_P_LOW     = 13'h0200,
      ST_P_SCL_REL = 13'h0400,
      ST_P_HIGH    = 13'h0800,
      ST_P_SDA_REL = 13'h1000
   } ims_state_t;

endpackage : ims_pkg

// File: sim/ims_far_end.sv
`timescale 1ns/1ps
module ims_far_end (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic sda_oe_n,
   input  wire logic scl_oe_n,
   input  wire logic hold_sda,
   input  wire logic hold_scl,
   input  wire logic slow,
   output logic      sda_in,
   output logic      scl_in
);
   logic [1:0] str_r;
   // Wired-AND lines with pull-ups, anyone may only pull low
   assign sda_in = sda_oe_n & ~hold_sda;
   assign scl_in = scl_oe_n & ~hold_scl & (str_r == 2'h0);
   // Slow slave keeps SCL low three more cycles after each release
   always_ff @(posedge aclk) begin
      if (!aresetn) str_r <= 2'h0;
      else if (!scl_oe_n) str_r <= slow ? 2'h3 : 2'h0;
      else if (str_r != 2'h0) str_r <= str_r - 2'h1;
   end
endmodule : ims_far_end

// File: sim/ims_properties.sv
`timescale 1ns/1ps
module ims_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_rvalid,
   input wire logic sda_out,
   input wire logic scl_out,
   input wire logic sda_oe_n,
   input wire logic scl_oe_n,
   input wire logic byte_busy,
   input wire logic tx_load
);
   // One clock domain, checks paused in reset
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////
   pull_low_a:
      assert property (!sda_out && !scl_out) else $error("line driven high");
   reset_idle_a:
      assert property ($rose(aresetn) |-> sda_oe_n && scl_oe_n) else $error("line held");
   busy_refuse_a:
      assert property (s_axi_awvalid && s_axi_awready && byte_busy |=> !tx_load)
         else $error("load while busy");
   load_pulse_a:
      assert property (tx_load |=> !tx_load) else $error("long load");
   start_hold_a:
      assert property ($fell(sda_oe_n) && scl_oe_n |=> !sda_oe_n [*3])
         else $error("data low short");
   restart_high_a:
      assert property ($fell(sda_oe_n) && scl_oe_n |=> scl_oe_n [*3])
         else $error("clock low early");
   scl_high_a:
      assert property ($rose(scl_oe_n) |=> scl_oe_n [*4]) else $error("clock high short");
   read_answer_a:
      assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
         else $error("no read answer");
   // Main scenarios reached
   start_c: cover property ($fell(sda_oe_n) && scl_oe_n);
   scl_rel_c: cover property ($rose(scl_oe_n));
   load_c: cover property (tx_load);
endmodule : ims_chk
////////////////////////////////////////////////////////////
bind ims_sequencer ims_chk u_ims_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid), .sda_out(sda_out),
   .scl_out(scl_out), .sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n),
   .byte_busy(byte_busy), .tx_load(tx_load));

// File: sim/ims_sequencer_tb_top.sv
`timescale 1ns/1ps
module ims_sequencer_tb_top;
   import ims_pkg::*;
   logic        aclk, aresetn, awv, wv, arv, awr, wrd, bv, arr, rvl, busy, hb;
   logic        hsda, hscl, slow, sda_in, scl_in, sda_oe_n, scl_oe_n, amatch;
   logic [7:0]  awa, ara, rsr, txd;
   logic [31:0] wd, rdata, rv;
   logic [1:0]  bresp, br;
   int          n_fail, n_tests, cyc;
   ////////////////////////////////////////////////////////////
   ims_sequencer u_ims_sequencer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(),
      .s_axi_rvalid(rvl), .s_axi_rready(1'b1), .sda_in(sda_in), .sda_out(),
      .sda_oe_n(sda_oe_n), .scl_in(scl_in), .scl_out(), .scl_oe_n(scl_oe_n),
      .byte_busy(busy), .rsr_byte(rsr), .rsr_high_byte(hb), .tx_data(txd), .tx_load(),
      .addr_match(amatch));
   ims_far_end u_ims_far_end (.aclk(aclk), .aresetn(aresetn), .sda_oe_n(sda_oe_n),
      .scl_oe_n(scl_oe_n), .hold_sda(hsda), .hold_scl(hscl), .slow(slow),
      .sda_in(sda_in), .scl_in(scl_in));
   // Clock and hang guard
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      if (n_fail == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   // Bus cycles, answers are always accepted
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      // Each channel is released at the edge its own ready is seen
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awr === 1'b1) aw_done = 1'b1;
         if (wrd === 1'b1) w_done = 1'b1;
         if (aw_done) awv <= 1'b0;
         if (w_done) wv <= 1'b0;
      end
      do @(posedge aclk); while (bv !== 1'b1);
      br = bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      ara <= a;
      arv <= 1'b1;
      do @(posedge aclk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge aclk); while (rvl !== 1'b1);
      rv = rdata;
   endtask : rd
   task automatic wait_clr(input int b);
      rd(OFS_CTRL_TWO);
      while (rv[b] !== 1'b0) rd(OFS_CTRL_TWO);
   endtask : wait_clr
   task automatic m(input logic h, input logic [7:0] b);
      hb <= h;
      rsr <= b;
      repeat (2) @(posedge aclk);
   endtask : m
   ////////////////////////////////////////////////////////////
   task automatic sc_start();
      rd(OFS_MASK);
      chk(rv, 32'hFF);
      wr(8'h20, 32'h0);
      chk(32'(br), 32'(RESP_SLVERR));
      wr(OFS_BAUD, 32'h3);
      wr(OFS_CTRL_ONE, 32'h10 | 32'(MODE_HW_MASTER));
      wr(OFS_CTRL_TWO, 32'h1);
      wr(OFS_CTRL_TWO, 32'h4);
      wr(OFS_TXBUF, 32'hA5);
      wait_clr(C2_START);
      chk(rv & 32'h7, 32'h0);
      chk(32'(sda_oe_n), 32'h0);
      rd(OFS_FLAGS);
      chk(rv & 32'h3, 32'h3);
      chk(32'(txd), 32'h0);
      rd(OFS_STATUS);
      chk(rv & 32'h3, 32'h1);
      wr(OFS_FLAGS, 32'h7);
   endtask : sc_start
   task automatic sc_restart();
      wr(OFS_TXBUF, 32'h5A);
      chk(32'(txd), 32'h5A);
      busy <= 1'b1;
      wr(OFS_TXBUF, 32'h3C);
      chk(32'(txd), 32'h5A);
      wr(OFS_CTRL_TWO, 32'h2);
      rd(OFS_CTRL_TWO);
      chk(rv & 32'h2, 32'h0);
      rd(OFS_FLAGS);
      chk(rv & 32'h2, 32'h2);
      busy <= 1'b0;
      slow <= 1'b1;
      wr(OFS_FLAGS, 32'h7);
      wr(OFS_CTRL_TWO, 32'h2);
      wait_clr(C2_RESTART);
      chk({30'h0, sda_oe_n, scl_oe_n}, 32'h0);
      rd(OFS_FLAGS);
      chk(rv & 32'h5, 32'h1);
      rd(OFS_STATUS);
      chk(rv & 32'h1, 32'h1);
   endtask : sc_restart
   task automatic sc_collide();
      wr(OFS_CTRL_TWO, 32'h4);
      wait_clr(C2_STOP);
      chk({30'h0, sda_oe_n, scl_oe_n}, 32'h3);
      hscl <= 1'b1;
      wr(OFS_FLAGS, 32'h7);
      hsda <= 1'b1;
      wr(OFS_CTRL_TWO, 32'h1);
      wait_clr(C2_START);
      rd(OFS_FLAGS);
      chk(rv & 32'h4, 32'h4);
      chk({30'h0, sda_oe_n, scl_oe_n}, 32'h3);
      hsda <= 1'b0;
      hscl <= 1'b0;
   endtask : sc_collide
   // Disable clears seen flags; firmware mode drives lines, detection reports
   task automatic sc_firmware();
      wr(OFS_CTRL_ONE, 32'h0);
      rd(OFS_STATUS);
      chk(rv & 32'h3, 32'h0);
      wr(OFS_CTRL_ONE, 32'h90 | 32'(MODE_FW_MASTER));
      chk({30'h0, sda_oe_n, scl_oe_n}, 32'h1);
      repeat (4) @(posedge aclk);
      rd(OFS_FLAGS);
      chk(rv & 32'h1, 32'h1);
      wr(OFS_FLAGS, 32'h7);
      wr(OFS_CTRL_ONE, 32'h10 | 32'(MODE_FW_MASTER));
      repeat (4) @(posedge aclk);
      rd(OFS_STATUS);
      chk(rv & 32'h3, 32'h2);
      rd(OFS_FLAGS);
      chk(rv & 32'h1, 32'h1);
   endtask : sc_firmware
   task automatic sc_mask();
      wr(OFS_OWN_ADDR, 32'h50);
      m(1'b0, 8'h51);
      chk(32'(amatch), 32'h1);
      wr(OFS_MASK, 32'hF0);
      m(1'b0, 8'h5A);
      chk(32'(amatch), 32'h1);
      wr(OFS_CTRL_ONE, 32'h30 | 32'(MODE_HW_MASTER));
      m(1'b1, 8'h5A);
      chk(32'(amatch), 32'h0);
   endtask : sc_mask
   // Main sequence
   initial begin
      {aresetn, awv, wv, arv, busy, hb, hsda, hscl, slow} = '0;
      {awa, ara, rsr, wd} = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      sc_start();
      sc_restart();
      sc_collide();
      sc_firmware();
      sc_mask();
      close_out();
   end
endmodule : ims_sequencer_tb_top
